// ===== bench/qcm_top_test.sv
// qcm_top_test: self-checking bench for the queue congestion monitor top
// assumes one 25 MHz clock; every strobe driven at rising edge by nonblocking assignment
`timescale 1ns/1ps
module qcm_top_test;
    import qcm_pkg::*;
    // ------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------
    localparam int S_EGP = 0, S_INP = 1, S_BIAS = 2, S_PICK = 3, S_EGW = 4;
    localparam int S_INW = 5, S_RDW = 6, S_EGR = 7, S_INR = 8, S_RDR = 9;
    logic               sys_clk;
    logic               nrst;
    qcm_cfg_t           eg_cfg;
    qcm_cfg_t           in_cfg;
    logic [CNT_W-1:0]   reorder_alarm_level;
    logic [9:0]         strb;
    logic [DEPTH_W-1:0] eg_queue_count;
    logic [DEPTH_W-1:0] in_queue_count;
    qcm_stat_t          eg_stat;
    qcm_stat_t          in_stat;
    logic [CNT_W-1:0]   reorder_count;
    logic               eg_flag;
    logic               in_flag;
    logic               rdr_flag;
    logic               notify_req;
    int                 error_cnt;
    int                 samples_checked;

    qcm_top u_dut (
        .sys_clk(sys_clk), .nrst(nrst), .eg_cfg(eg_cfg), .in_cfg(in_cfg),
        .reorder_alarm_level(reorder_alarm_level),
        .eg_pkt_done(strb[S_EGP]), .eg_queue_count(eg_queue_count),
        .in_pkt_done(strb[S_INP]), .in_queue_count(in_queue_count),
        .bias_tick(strb[S_BIAS]), .reorder_pick(strb[S_PICK]),
        .eg_flag_w1c(strb[S_EGW]), .in_flag_w1c(strb[S_INW]), .rdr_flag_w1c(strb[S_RDW]),
        .eg_ticks_read(strb[S_EGR]), .in_ticks_read(strb[S_INR]),
        .reorder_read(strb[S_RDR]), .eg_stat(eg_stat), .in_stat(in_stat),
        .reorder_count(reorder_count), .egress_pressure_flag(eg_flag),
        .ingress_pressure_flag(in_flag), .reorder_alarm_flag(rdr_flag),
        .notify_req(notify_req)
    );

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // strobe held n cycles, outputs of the last taken cycle visible on return
    task automatic pulse(int idx, int n);
        @(posedge sys_clk);
        strb[idx] <= 1'b1;
        repeat (n) @(posedge sys_clk);
        strb[idx] <= 1'b0;
        #1;
    endtask

    task automatic restart(qcm_cfg_t e, qcm_cfg_t i, logic [CNT_W-1:0] rl);
        @(posedge sys_clk);
        nrst <= 1'b0;
        eg_cfg <= e;
        in_cfg <= i;
        reorder_alarm_level <= rl;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_reset;
        check("eg_stat", eg_stat, 32'h0000_0000);
        check("in_stat", in_stat, 32'h0000_0000);
        check("reorder_count", reorder_count, 32'h0000_0000);
        check("flags", {eg_flag, in_flag, rdr_flag, notify_req}, 32'h0);
    endtask

    task automatic sc_egress_alarm;
        @(posedge sys_clk) eg_queue_count <= 8'h04;
        pulse(S_EGP, 1);
        check("eg score at depth", eg_stat.pressure_score, 32'h0);
        @(posedge sys_clk) eg_queue_count <= 8'h05;
        pulse(S_EGP, 3);
        check("eg score", eg_stat.pressure_score, 32'h3);
        check("eg flag early", {eg_flag, notify_req}, 32'h0);
        step(1);
        check("eg flag set", {eg_flag, notify_req}, 32'h3);
        step(1);
        check("notify one cycle", {eg_flag, notify_req}, 32'h2);
        pulse(S_EGW, 1);
        check("eg score cleared", eg_stat.pressure_score, 32'h0);
        check("eg flag cleared", eg_flag, 32'h0);
    endtask

    // bias decrements both, floor at zero
    task automatic sc_bias;
        @(posedge sys_clk) eg_queue_count <= 8'h05;
        in_queue_count <= 8'h05;
        pulse(S_EGP, 2);
        pulse(S_INP, 1);
        pulse(S_BIAS, 1);
        check("eg score bias", eg_stat.pressure_score, 32'h1);
        check("in score bias", in_stat.pressure_score, 32'h0);
        pulse(S_BIAS, 2);
        check("eg score floor", eg_stat.pressure_score, 32'h0);
        check("in score floor", in_stat.pressure_score, 32'h0);
    endtask

    task automatic sc_decay;
        logic [CNT_W-1:0] v;
        int               i;
        @(posedge sys_clk) eg_queue_count <= 8'h05;
        pulse(S_EGP, 5);
        v = eg_stat.pressure_score;
        for (i = 0; i < 20 && eg_stat.pressure_score === v; i++) step(1);
        if (i == 20) begin
            check("decay tick seen", 32'h0, 32'h1);
            tally_and_finish;
        end
        v = eg_stat.pressure_score;
        step(7);
        check("no early decay", eg_stat.pressure_score, v);
        step(1);
        check("decay one", eg_stat.pressure_score, v - 16'h0001);
        step(8);
        check("decay two", eg_stat.pressure_score, v - 16'h0002);
    endtask

    task automatic sc_ingress_ticks;
        int i;
        step(25);
        check("ticks with zero score", in_stat.over_level_tick_count, 32'h0);
        check("eg ticks with zero score", eg_stat.over_level_tick_count, 32'h0);
        @(posedge sys_clk) in_queue_count <= 8'h03;
        pulse(S_INP, 1);
        check("in score", in_stat.pressure_score, 32'h1);
        step(2);
        check("in and eg flags", {in_flag, eg_flag}, 32'h2);
        for (i = 0; i < 25 && in_stat.over_level_tick_count === 16'h0; i++) step(1);
        check("first tick", in_stat.over_level_tick_count, 32'h1);
        step(10);
        check("second tick", in_stat.over_level_tick_count, 32'h2);
        pulse(S_INR, 1);
        check("ticks cleared by read", in_stat.over_level_tick_count, 32'h0);
        pulse(S_INW, 1);
        check("in score cleared", in_stat.pressure_score, 32'h0);
        check("in flag cleared", in_flag, 32'h0);
        @(posedge sys_clk) eg_queue_count <= 8'h05;
        pulse(S_EGP, 1);
        for (i = 0; i < 25 && eg_stat.over_level_tick_count === 16'h0; i++) step(1);
        check("eg first tick", eg_stat.over_level_tick_count, 32'h1);
        pulse(S_EGR, 1);
        check("eg ticks cleared by read", eg_stat.over_level_tick_count, 32'h0);
    endtask

    task automatic sc_reorder;
        pulse(S_PICK, 2);
        check("reorder two", reorder_count, 32'h2);
        step(2);
        check("reorder flag at level", rdr_flag, 32'h0);
        pulse(S_PICK, 1);
        check("reorder three", reorder_count, 32'h3);
        step(2);
        check("reorder flag over", rdr_flag, 32'h1);
        pulse(S_RDR, 1);
        check("reorder read", reorder_count, 32'h0);
        pulse(S_RDW, 1);
        step(1);
        check("reorder flag cleared", rdr_flag, 32'h0);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        nrst = 1'b0;
        strb = 10'h000;
        eg_queue_count = 8'h00;
        in_queue_count = 8'h00;
        eg_cfg = '0;
        in_cfg = '0;
        reorder_alarm_level = 16'h0000;
        restart('{8'h04, 16'h0000, 16'h0000, 16'h0002}, '{8'h04, 16'h0, 16'h0, 16'hffff},
                16'h0002);
        sc_reset;
        sc_egress_alarm;
        restart('{8'h04, 16'h0000, 16'h0000, 16'h0002}, '{8'h04, 16'h0, 16'h0, 16'hffff},
                16'h0002);
        sc_bias;
        sc_reorder;
        restart('{8'h04, 16'h0000, 16'h0008, 16'hffff}, '{8'h04, 16'h0, 16'h0, 16'hffff},
                16'hffff);
        sc_decay;
        restart('{8'h04, 16'h000a, 16'h0000, 16'hffff}, '{8'h02, 16'h000a, 16'h0, 16'h0000},
                16'hffff);
        sc_ingress_ticks;
        tally_and_finish;
    end
endmodule // qcm_top_test

// ===== rtl/qcm_dir.sv
// qcm_dir: pressure score and over-level tick logic for one queue direction
// assumes packet-done strobes and queue count come from the same clock
`timescale 1ns/1ps
module qcm_dir
    import qcm_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire qcm_cfg_t           cfg,
    input  wire logic               pkt_done,
    input  wire logic [DEPTH_W-1:0] queue_count,
    input  wire logic               bias_tick,
    input  wire logic               score_clear,
    input  wire logic               tick_count_read,
    output qcm_stat_t               stat,
    output logic                    over_alarm
);
    logic [TMR_W-1:0] per_tmr_reg;
    logic [TMR_W-1:0] dec_tmr_reg;
    logic             per_tick;
    logic             dec_tick;
    logic [CNT_W-1:0] score_reg;
    logic [CNT_W-1:0] score_next;
    logic [CNT_W-1:0] ticks_reg;
    logic             inc;
    logic [1:0]       ndec;

    // ------------------------------------------------------------
    // tick timers
    // ------------------------------------------------------------
    // timer restart
    assign per_tick = (cfg.tick_interval_setting != TMR_RST) &&
                      (per_tmr_reg + TMR_ONE >= cfg.tick_interval_setting);
    assign dec_tick = (cfg.decay_interval_setting != TMR_RST) &&
                      (dec_tmr_reg + TMR_ONE >= cfg.decay_interval_setting);

    always_ff @(posedge sys_clk) begin
        if (!nrst || per_tick) begin
            per_tmr_reg <= TMR_RST;
        end else if (cfg.tick_interval_setting != TMR_RST) begin
            per_tmr_reg <= per_tmr_reg + TMR_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst || dec_tick) begin
            dec_tmr_reg <= TMR_RST;
        end else if (cfg.decay_interval_setting != TMR_RST) begin
            dec_tmr_reg <= dec_tmr_reg + TMR_ONE;
        end
    end

    // ------------------------------------------------------------
    // pressure score
    // ------------------------------------------------------------
    // over-level test
    assign inc  = pkt_done && (queue_count > cfg.depth_level);
    assign ndec = {1'b0, dec_tick} + {1'b0, bias_tick};

    always_comb begin
        score_next = score_reg;
        if (inc && score_next != CNT_MAX) begin
            score_next = score_next + 16'h0001;
        end
        if (score_next >= {14'h0000, ndec}) begin
            score_next = score_next - {14'h0000, ndec};
        end else begin
            score_next = CNT_RST;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            score_reg <= CNT_RST;
        end else if (score_clear) begin
            score_reg <= CNT_RST;
        end else begin
            score_reg <= score_next;
        end
    end

    // ------------------------------------------------------------
    // over-level tick count
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ticks_reg <= CNT_RST;
        end else if (per_tick && score_reg != CNT_RST && ticks_reg != CNT_MAX) begin
            ticks_reg <= tick_count_read ? 16'h0001 : ticks_reg + 16'h0001;
        end else if (tick_count_read) begin
            ticks_reg <= CNT_RST;
        end
    end

    assign stat.pressure_score        = score_reg;
    assign stat.over_level_tick_count = ticks_reg;
    assign over_alarm = score_reg > cfg.pressure_alarm_level;

    AST_DIR_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst)
        score_clear |=> score_reg == CNT_RST)
        else $error("score not cleared");
    AST_DIR_INC: assert property (@(posedge sys_clk) disable iff (!nrst)
        (inc && !score_clear && ndec == 2'b00 && score_reg != CNT_MAX)
        |=> score_reg == $past(score_reg) + 16'h0001)
        else $error("score missed inc");
    AST_DIR_DEC: assert property (@(posedge sys_clk) disable iff (!nrst)
        (dec_tick && !inc && !bias_tick && !score_clear && score_reg != CNT_RST)
        |=> score_reg == $past(score_reg) - 16'h0001)
        else $error("score missed decay");
    AST_DIR_BIAS: assert property (@(posedge sys_clk) disable iff (!nrst)
        (bias_tick && !dec_tick && !inc && !score_clear && score_reg != CNT_RST)
        |=> score_reg == $past(score_reg) - 16'h0001)
        else $error("score missed bias");
    AST_DIR_TICK: assert property (@(posedge sys_clk) disable iff (!nrst)
        (per_tick && score_reg != CNT_RST && !tick_count_read && ticks_reg != CNT_MAX)
        |=> ticks_reg == $past(ticks_reg) + 16'h0001)
        else $error("tick count missed");
    AST_DIR_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!per_tick && !tick_count_read) |=> $stable(ticks_reg))
        else $error("tick count moved");
    AST_DIR_TMR: assert property (@(posedge sys_clk) disable iff (!nrst)
        per_tick |=> per_tmr_reg == TMR_RST)
        else $error("timer not restarted");
    COV_DIR_ALARM: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(over_alarm));
endmodule // qcm_dir

// ===== rtl/qcm_pkg.sv
// qcm_pkg: constants and carrier types for the queue congestion monitor
// assumes one register-domain clock and plain-port configuration
package qcm_pkg;
    localparam int CNT_W  = 16;
    localparam int DEPTH_W = 8;
    localparam int TMR_W  = 16;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
    localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;

    // per-direction configuration
    typedef struct packed {
        logic [DEPTH_W-1:0] depth_level;
        logic [TMR_W-1:0]   tick_interval_setting;
        logic [TMR_W-1:0]   decay_interval_setting;
        logic [CNT_W-1:0]   pressure_alarm_level;
    } qcm_cfg_t;

    // per-direction status
    typedef struct packed {
        logic [CNT_W-1:0] pressure_score;
        logic [CNT_W-1:0] over_level_tick_count;
    } qcm_stat_t;
endpackage

// ===== rtl/qcm_top.sv
// qcm_top: per-port congestion monitor, egress and ingress copies plus reorder count
// assumes all strobes are on sys_clk; bias tick comes from the port error logic
`timescale 1ns/1ps
module qcm_top
    import qcm_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire qcm_cfg_t           eg_cfg,
    input  wire qcm_cfg_t           in_cfg,
    input  wire logic [CNT_W-1:0]   reorder_alarm_level,
    input  wire logic               eg_pkt_done,
    input  wire logic [DEPTH_W-1:0] eg_queue_count,
    input  wire logic               in_pkt_done,
    input  wire logic [DEPTH_W-1:0] in_queue_count,
    input  wire logic               bias_tick,
    input  wire logic               reorder_pick,
    input  wire logic               eg_flag_w1c,
    input  wire logic               in_flag_w1c,
    input  wire logic               rdr_flag_w1c,
    input  wire logic               eg_ticks_read,
    input  wire logic               in_ticks_read,
    input  wire logic               reorder_read,
    output qcm_stat_t               eg_stat,
    output qcm_stat_t               in_stat,
    output logic [CNT_W-1:0]        reorder_count,
    output logic                    egress_pressure_flag,
    output logic                    ingress_pressure_flag,
    output logic                    reorder_alarm_flag,
    output logic                    notify_req
);
    logic             eg_alarm;
    logic             in_alarm;
    logic [CNT_W-1:0] rdr_reg;
    logic             eg_flag_reg;
    logic             in_flag_reg;
    logic             rdr_flag_reg;
    logic             notify_reg;

    // ------------------------------------------------------------
    // direction copies
    // ------------------------------------------------------------
    qcm_dir u_egress (
        .sys_clk         (sys_clk),
        .nrst            (nrst),
        .cfg             (eg_cfg),
        .pkt_done        (eg_pkt_done),
        .queue_count     (eg_queue_count),
        .bias_tick       (bias_tick),
        .score_clear     (eg_flag_w1c),
        .tick_count_read (eg_ticks_read),
        .stat            (eg_stat),
        .over_alarm      (eg_alarm)
    );

    qcm_dir u_ingress (
        .sys_clk         (sys_clk),
        .nrst            (nrst),
        .cfg             (in_cfg),
        .pkt_done        (in_pkt_done),
        .queue_count     (in_queue_count),
        .bias_tick       (bias_tick),
        .score_clear     (in_flag_w1c),
        .tick_count_read (in_ticks_read),
        .stat            (in_stat),
        .over_alarm      (in_alarm)
    );

    // ------------------------------------------------------------
    // egress pressure flag
    // ------------------------------------------------------------
    // set on alarm
    // clear wins: the same write empties the score, so an alarm seen with it is stale
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            eg_flag_reg <= 1'b0;
        end else if (eg_alarm && !eg_flag_w1c) begin
            eg_flag_reg <= 1'b1;
        end else if (eg_flag_w1c) begin
            eg_flag_reg <= 1'b0;
        end
    end

    AST_EG_FLAG: assert property (@(posedge sys_clk) disable iff (!nrst)
        (eg_alarm && !eg_flag_w1c) |=> egress_pressure_flag)
        else $error("eg flag not set");
    AST_EG_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
        (egress_pressure_flag && !eg_flag_w1c) |=> egress_pressure_flag)
        else $error("eg flag dropped");
    AST_EG_RISE: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(egress_pressure_flag) |-> $past(eg_alarm))
        else $error("eg flag set without alarm");
    AST_EG_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
        eg_flag_w1c |=> !egress_pressure_flag)
        else $error("eg flag not cleared");

    // ------------------------------------------------------------
    // ingress pressure flag
    // ------------------------------------------------------------
    // ingress flag
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            in_flag_reg <= 1'b0;
        end else if (in_alarm && !in_flag_w1c) begin
            in_flag_reg <= 1'b1;
        end else if (in_flag_w1c) begin
            in_flag_reg <= 1'b0;
        end
    end

    AST_IN_FLAG: assert property (@(posedge sys_clk) disable iff (!nrst)
        (in_alarm && !in_flag_w1c) |=> ingress_pressure_flag)
        else $error("in flag not set");
    AST_IN_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
        (ingress_pressure_flag && !in_flag_w1c) |=> ingress_pressure_flag)
        else $error("in flag dropped");
    AST_IN_RISE: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(ingress_pressure_flag) |-> $past(in_alarm))
        else $error("in flag set without alarm");
    AST_IN_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_flag_w1c |=> !ingress_pressure_flag)
        else $error("in flag not cleared");
    COV_IN: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(ingress_pressure_flag));

    // ------------------------------------------------------------
    // in-band notification request
    // ------------------------------------------------------------
    // notify on rise
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            notify_reg <= 1'b0;
        end else begin
            notify_reg <= eg_alarm && !eg_flag_w1c && !eg_flag_reg;
        end
    end

    AST_NOTIFY: assert property (@(posedge sys_clk) disable iff (!nrst)
        notify_req |-> $rose(egress_pressure_flag))
        else $error("stray notify");
    AST_NOTIFY_RISE: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(egress_pressure_flag) |-> notify_req)
        else $error("notify missed");
    AST_NOTIFY_ONE: assert property (@(posedge sys_clk) disable iff (!nrst)
        notify_req |=> !notify_req)
        else $error("notify longer than one cycle");
    COV_NOTIFY: cover property (@(posedge sys_clk) disable iff (!nrst) notify_req);

    // ------------------------------------------------------------
    // reorder count
    // ------------------------------------------------------------
    // a read in the same cycle as a pick keeps that pick unless the count is at CNT_MAX
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdr_reg <= CNT_RST;
        end else if (reorder_pick && rdr_reg != CNT_MAX) begin
            rdr_reg <= reorder_read ? 16'h0001 : rdr_reg + 16'h0001;
        end else if (reorder_read) begin
            rdr_reg <= CNT_RST;
        end
    end

    AST_RDR_INC: assert property (@(posedge sys_clk) disable iff (!nrst)
        (reorder_pick && !reorder_read && rdr_reg != CNT_MAX)
        |=> rdr_reg == $past(rdr_reg) + 16'h0001)
        else $error("reorder missed");
    AST_RDR_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
        (reorder_read && !reorder_pick) |=> reorder_count == CNT_RST)
        else $error("reorder count not cleared by read");
    AST_RDR_SAT: assert property (@(posedge sys_clk) disable iff (!nrst)
        (rdr_reg == CNT_MAX && !reorder_read) |=> rdr_reg == CNT_MAX)
        else $error("wrap");

    // ------------------------------------------------------------
    // reorder alarm flag
    // ------------------------------------------------------------
    // reorder alarm
    // the level test wins, so a write drops the flag only once the count is at or below reorder_alarm_level
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdr_flag_reg <= 1'b0;
        end else if (rdr_reg > reorder_alarm_level) begin
            rdr_flag_reg <= 1'b1;
        end else if (rdr_flag_w1c) begin
            rdr_flag_reg <= 1'b0;
        end
    end

    AST_RDR_FLAG: assert property (@(posedge sys_clk) disable iff (!nrst)
        (rdr_reg > reorder_alarm_level) |=> reorder_alarm_flag)
        else $error("rdr flag");
    AST_RDR_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
        (reorder_alarm_flag && !rdr_flag_w1c) |=> reorder_alarm_flag)
        else $error("rdr flag dropped");
    AST_RDR_FALL: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(reorder_alarm_flag) |-> $past(rdr_flag_w1c))
        else $error("rdr flag fell without write");
    AST_RDR_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
        (rdr_flag_w1c && rdr_reg <= reorder_alarm_level) |=> !reorder_alarm_flag)
        else $error("rdr flag not cleared");
    COV_RDR: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(reorder_alarm_flag));

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reorder_count         = rdr_reg;
    assign egress_pressure_flag  = eg_flag_reg;
    assign ingress_pressure_flag = in_flag_reg;
    assign reorder_alarm_flag    = rdr_flag_reg;
    assign notify_req            = notify_reg;

    // outputs read zero one cycle after a sampled reset
    AST_RST: assert property (@(posedge sys_clk)
        !nrst |=> (eg_stat == '0
            && in_stat == '0
            && reorder_count == CNT_RST
            && !egress_pressure_flag
            && !ingress_pressure_flag
            && !reorder_alarm_flag
            && !notify_req))
        else $error("outputs not cleared by reset");
endmodule // qcm_top
